// ### hdl/ipr_pkg.sv
// Constants for the interrupt priority register bank.
// Assumes a 32-bit APB slave port with byte addresses and one word per register.
package ipr_pkg;

    // Bank geometry
    localparam int unsigned IPR_NREG = 5;
    localparam int unsigned IPR_SLOTS = 4;
    localparam int unsigned IPR_NFLD = 20;
    localparam int unsigned IPR_FW = 3;
    localparam int unsigned IPR_SLOT_PITCH = 4;
    localparam int unsigned IPR_RW = 16;
    localparam int unsigned IPR_AW = 12;

    // Byte offsets of the five registers
    localparam logic [11:0] IPR_OFF_PRIORITY_CTRL_0 = 12'h000;
    localparam logic [11:0] IPR_OFF_PRIORITY_CTRL_1 = 12'h004;
    localparam logic [11:0] IPR_OFF_PRIORITY_CTRL_2 = 12'h008;
    localparam logic [11:0] IPR_OFF_PRIORITY_CTRL_3 = 12'h00C;
    localparam logic [11:0] IPR_OFF_PRIORITY_CTRL_4 = 12'h010;

    // Level codes
    localparam logic [2:0] IPR_LVL_OFF = 3'h0;
    localparam logic [2:0] IPR_LVL_MIN = 3'h1;
    localparam logic [2:0] IPR_LVL_MAX = 3'h7;
    localparam logic [2:0] IPR_LVL_RST = 3'h4;

    // Implemented bits per register, highest register first
    localparam logic [15:0] IPR_MASK_FULL = 16'h7777;
    localparam logic [15:0] IPR_MASK_PC3 = 16'h0777;
    localparam logic [IPR_NREG-1:0][15:0] IPR_MASK = {IPR_MASK_FULL, IPR_MASK_PC3, IPR_MASK_FULL,
                                                      IPR_MASK_FULL, IPR_MASK_FULL};
    localparam logic [15:0] IPR_RST_WORD = {4{1'b0, IPR_LVL_RST}};

    // Field index = register * 4 + slot, slot 0 at bits 2-0
    localparam int unsigned F_EXT_IRQ_ZERO_LEVEL = 0;
    localparam int unsigned F_INCAP_ONE_LEVEL = 1;
    localparam int unsigned F_OUTCMP_ONE_LEVEL = 2;
    localparam int unsigned F_TIMER_ONE_LEVEL = 3;
    localparam int unsigned F_DMA_CH_ZERO_LEVEL = 4;
    localparam int unsigned F_INCAP_TWO_LEVEL = 5;
    localparam int unsigned F_OUTCMP_TWO_LEVEL = 6;
    localparam int unsigned F_TIMER_TWO_LEVEL = 7;
    localparam int unsigned F_TIMER_THREE_LEVEL = 8;
    localparam int unsigned F_SPI_ONE_ERROR_LEVEL = 9;
    localparam int unsigned F_SPI_ONE_EVENT_LEVEL = 10;
    localparam int unsigned F_UART_ONE_RX_LEVEL = 11;
    localparam int unsigned F_UART_ONE_TX_LEVEL = 12;
    localparam int unsigned F_ADC_DONE_LEVEL = 13;
    localparam int unsigned F_DMA_CH_ONE_LEVEL = 14;
    localparam int unsigned F_UNUSED_PC3_TOP = 15;
    localparam int unsigned F_I2C_SLAVE_LEVEL = 16;
    localparam int unsigned F_I2C_MASTER_LEVEL = 17;
    localparam int unsigned F_COMPARATOR_LEVEL = 18;
    localparam int unsigned F_PIN_CHANGE_LEVEL = 19;

    // Slave port sequencing
    typedef enum logic [1:0] {
        IPR_ST_IDLE = 2'b01,
        IPR_ST_ARMED = 2'b10
    } ipr_state_t;

endpackage

// ### hdl/ipr_fld_if.sv
// Carrier between the register bank and the level decoder.
// Assumes both ends run on the same clock; it carries no state.
`timescale 1ns/1ns
`default_nettype none
interface ipr_fld_if #(
    parameter int unsigned NF = 20
) ();
    logic [3*NF-1:0] code;
    logic [NF-1:0] req;
    logic [NF-1:0] enable;
    logic [3*NF-1:0] level;
    logic [NF-1:0] gated;

    modport bank (output code, output req, input enable, input level, input gated);
    modport dec (input code, input req, output enable, output level, output gated);
endinterface
`default_nettype wire

// ### hdl/ipr_decode.sv
// Per-source decode of a priority code into enable, level and gated request.
// Assumes codes come straight from the register flops; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module ipr_decode #(
    parameter int unsigned NF = ipr_pkg::IPR_NFLD
) (
    input wire logic clk_sys,
    input wire logic resetn,
    ipr_fld_if.dec fld
);
    import ipr_pkg::*;

    for (genvar f = 0; f < NF; f++) begin : g_fld
        // Codes map one to one onto levels 0..7
        assign fld.level[3*f +: 3] = fld.code[3*f +: 3];
        // A zero code disables the source outright
        assign fld.enable[f] = (fld.code[3*f +: 3] != IPR_LVL_OFF);
        assign fld.gated[f] = fld.req[f] & fld.enable[f];

        AST_MIN_LEVEL: assert property (@(posedge clk_sys) disable iff (!resetn)
            (fld.code[3*f +: 3] == IPR_LVL_MIN) |-> (fld.enable[f] && fld.level[3*f +: 3] == 3'h1))
            else $error("lowest code does not give enabled level one");

        AST_OFF_BLOCKS: assert property (@(posedge clk_sys) disable iff (!resetn)
            (fld.code[3*f +: 3] == IPR_LVL_OFF && fld.req[f]) |-> !fld.gated[f])
            else $error("disabled source passed its request");
    end

endmodule
`default_nettype wire

// ### hdl/ipr_bank.sv
// Interrupt priority register bank: five 16-bit priority registers on APB.
// Assumes APB3/APB4 master on clk_sys; request inputs are synchronous to clk_sys.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ipr_bank #(
    parameter int unsigned AW = ipr_pkg::IPR_AW,
    parameter int unsigned NF = ipr_pkg::IPR_NFLD
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NF-1:0] src_req,
    output logic [3*NF-1:0] src_level,
    output logic [NF-1:0] src_enable,
    output logic [NF-1:0] src_req_gated,
    output logic cpu_req,
    output logic [2:0] cpu_level
);
    import ipr_pkg::*;

    ipr_state_t state_q;
    ipr_state_t state_d;
    logic [15:0] pc_q [IPR_NREG];
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic cpu_req_q;
    logic [2:0] cpu_level_q;
    logic [2:0] cpu_level_d;
    logic cpu_req_d;
    logic addr_hit;
    logic [2:0] addr_idx;
    logic setup_ph;
    logic access_ph;
    logic wr_fire;
    logic [15:0] wr_lanes;

    ipr_fld_if #(.NF(NF)) fld ();

    ipr_decode #(.NF(NF)) u_decode (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .fld(fld.dec)
    );

    // Address decode: one aligned word per register, upper address bits must be zero
    assign addr_idx = paddr[4:2];
    assign addr_hit = (paddr[1:0] == 2'h0) && (paddr[AW-1:5] == '0) && (addr_idx < 3'(IPR_NREG));

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;

    // Zero-wait access phase; a frozen clock enable holds the transfer off
    assign pready = access_ph && clk_en && (state_q == IPR_ST_ARMED);
    assign wr_fire = pready && pwrite && addr_hit;
    assign wr_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        state_d = state_q;
        case (state_q)
            IPR_ST_IDLE: begin
                if (setup_ph) begin
                    state_d = IPR_ST_ARMED;
                end
            end
            IPR_ST_ARMED: begin
                if (pready || !psel) begin
                    state_d = IPR_ST_IDLE;
                end
            end
            default: begin
                state_d = IPR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= IPR_ST_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Read data is staged at the setup edge so prdata comes from a flop
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (clk_en && setup_ph) begin
            if (addr_hit && !pwrite) begin
                prdata_q <= {16'h0000, pc_q[addr_idx]};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pslverr_q <= 1'b0;
        end else if (clk_en && setup_ph) begin
            pslverr_q <= !addr_hit;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q && pready;

    // Register storage; unimplemented bits are masked on write so they stay zero
    for (genvar r = 0; r < IPR_NREG; r++) begin : g_reg
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                pc_q[r] <= IPR_RST_WORD & IPR_MASK[r];
            end else if (clk_en && wr_fire && (addr_idx == 3'(r))) begin
                pc_q[r] <= ((pc_q[r] & ~wr_lanes) | (pwdata[15:0] & wr_lanes)) & IPR_MASK[r];
            end
        end
    end

    // Field f sits in register f/4 at bit (f%4)*4; the unused top slot of register 3 reads as zero
    for (genvar f = 0; f < NF; f++) begin : g_map
        assign fld.code[3*f +: 3] = pc_q[f / IPR_SLOTS][(f % IPR_SLOTS) * IPR_SLOT_PITCH +: IPR_FW];
    end

    assign fld.req = src_req & ~(NF'(1) << F_UNUSED_PC3_TOP);

    // Levels come straight from the register flops, no extra delay
    assign src_level = fld.level;
    assign src_enable = fld.enable;
    assign src_req_gated = fld.gated;

    // Highest level among gated requests; ties go to the lower index, which the fixed
    // order of the arbiter downstream resolves anyway
    always_comb begin
        cpu_level_d = IPR_LVL_OFF;
        cpu_req_d = 1'b0;
        for (int i = 0; i < NF; i++) begin
            if (fld.gated[i] && (fld.level[3*i +: 3] > cpu_level_d)) begin
                cpu_level_d = fld.level[3*i +: 3];
            end
        end
        cpu_req_d = |fld.gated;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cpu_level_q <= IPR_LVL_OFF;
            cpu_req_q <= 1'b0;
        end else if (clk_en) begin
            cpu_level_q <= cpu_level_d;
            cpu_req_q <= cpu_req_d;
        end
    end

    assign cpu_level = cpu_level_q;
    assign cpu_req = cpu_req_q;

    // Helper: marks the first edge after reset release
    logic seen_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            seen_q <= 1'b0;
        end else if (clk_en) begin
            seen_q <= 1'b1;
        end
    end

    AST_RESET_LEVEL: assert property (@(posedge clk_sys) disable iff (!resetn)
        !seen_q |-> (pc_q[0] == 16'h4444 && pc_q[3] == 16'h0444 && pc_q[4] == 16'h4444))
        else $error("priority fields did not reset to level four");

    AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        (pc_q[0][15] == 1'b0 && pc_q[1][11] == 1'b0 && pc_q[2][7] == 1'b0 && pc_q[4][3] == 1'b0))
        else $error("unimplemented bit became set");

    AST_PC3_TOP_CLEAR: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_fire && addr_idx == 3'h3) |=> (pc_q[3][15:11] == 5'h00 && src_level[3*F_UNUSED_PC3_TOP +: 3] == 3'h0))
        else $error("register 3 upper bits took a write");

    AST_TIMER_ONE_FIELD: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_fire && addr_idx == 3'h0 && pstrb[1]) |=>
        (src_level[3*F_TIMER_ONE_LEVEL +: 3] == $past(pwdata[14:12]) &&
         src_level[3*F_OUTCMP_ONE_LEVEL +: 3] == $past(pwdata[10:8])))
        else $error("register 0 high fields misplaced");

    AST_DMA_ZERO_FIELD: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_fire && addr_idx == 3'h1 && pstrb[0]) |=>
        (src_level[3*F_DMA_CH_ZERO_LEVEL +: 3] == $past(pwdata[2:0]) &&
         src_level[3*F_INCAP_TWO_LEVEL +: 3] == $past(pwdata[6:4])))
        else $error("register 1 low fields misplaced");

    AST_PIN_CHANGE_FIELD: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_fire && addr_idx == 3'h4 && pstrb[1]) |=>
        (src_level[3*F_PIN_CHANGE_LEVEL +: 3] == $past(pwdata[14:12]) &&
         src_level[3*F_COMPARATOR_LEVEL +: 3] == $past(pwdata[10:8])))
        else $error("register 4 high fields misplaced");

    AST_READ_BACK: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup_ph && clk_en && !pwrite && addr_hit && state_q == IPR_ST_IDLE) |=>
        (prdata[31:16] == 16'h0000 && prdata[15:0] == $past(pc_q[addr_idx])))
        else $error("read data does not match the register");

    AST_TOP_WINS: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && (fld.gated & fld.enable) != '0 &&
         fld.gated[F_TIMER_ONE_LEVEL] && src_level[3*F_TIMER_ONE_LEVEL +: 3] == IPR_LVL_MAX) |=>
        (cpu_req && cpu_level == 3'h7))
        else $error("level seven request not presented as highest");

    AST_NO_REQ_WHEN_OFF: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && fld.gated == '0) |=> !cpu_req)
        else $error("request reached the CPU with every source gated off");

    AST_LEVEL_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && src_req_gated != '0) |=> (cpu_level != 3'h0 && cpu_level >= $past(cpu_level_d)))
        else $error("presented level is not the highest pending one");

    AST_UNMAPPED_ERR: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup_ph && clk_en && !addr_hit && state_q == IPR_ST_IDLE) ##1 pready |-> pslverr)
        else $error("unmapped address answered without error");

endmodule
`default_nettype wire

// ### tb/ipr_arb_model.sv
// Stand-in for the arbitration logic: highest level among gated requests.
// Assumes levels and gated requests come straight from the bank.
`timescale 1ns/1ns
`default_nettype none
module ipr_arb_model (
    input wire logic [3*ipr_pkg::IPR_NFLD-1:0] src_level,
    input wire logic [ipr_pkg::IPR_NFLD-1:0] src_req_gated,
    output logic [2:0] win_level
);
    import ipr_pkg::*;
    // A disabled source never shows up gated, so it can never win
    always_comb begin
        win_level = IPR_LVL_OFF;
        for (int f = 0; f < IPR_NFLD; f++) begin
            if (src_req_gated[f] && (src_level[3*f+:3] > win_level)) begin
                win_level = src_level[3*f+:3];
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/ipr_bank_tb.sv
// Self-checking bench for the priority register bank over APB.
// Assumes the bank answers with its own pready; assertions live in the design.
`timescale 1ns/1ns
`default_nettype none
module ipr_bank_tb;
    import ipr_pkg::*;
    logic clk_sys, resetn, clk_en, psel, penable, pwrite, pready, pslverr, cpu_req, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [IPR_NFLD-1:0] src_req, src_enable, src_req_gated;
    logic [3*IPR_NFLD-1:0] src_level;
    logic [2:0] cpu_level, win_level;
    logic [2:0] code_of_slot [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
    int fails, checked;

    ipr_bank dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_req(src_req), .src_level(src_level), .src_enable(src_enable),
        .src_req_gated(src_req_gated), .cpu_req(cpu_req), .cpu_level(cpu_level));
    ipr_arb_model arb (.src_level(src_level), .src_req_gated(src_req_gated), .win_level(win_level));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ready, read data and error are taken at the rising edge that completes the access
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        rdy = 1'b0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int n = 0; n < 50 && !rdy; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) begin
                rdy = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!rdy) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
    endtask

    initial begin
        repeat (4000) @(posedge clk_sys);
        fails++;
        conclude();
    end

    initial begin
        fails = 0;
        checked = 0;
        resetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        src_req = '0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int r = 0; r < 5; r++) begin
            apb(1'b0, 12'(4 * r), 32'h0);
            chk(rd, (r == 3) ? 32'h0000_0444 : 32'h0000_4444);
            chk(32'(err), 32'h0);
        end
        chk(32'(src_enable), 32'h000F_7FFF);
        $display("test reset values done");
        for (int r = 0; r < 5; r++) begin
            apb(1'b1, 12'(4 * r), 32'h0000_FFFF);
            apb(1'b0, 12'(4 * r), 32'h0);
            chk(rd, (r == 3) ? 32'h0000_0777 : 32'h0000_7777);
            apb(1'b1, 12'(4 * r), 32'h0000_F5B9);
            apb(1'b0, 12'(4 * r), 32'h0);
            chk(rd, (r == 3) ? 32'h0000_0531 : 32'h0000_7531);
            for (int s = 0; s < 4; s++) begin
                chk(32'(src_level[3*(4*r+s)+:3]), (r == 3 && s == 3) ? 32'h0 : 32'(code_of_slot[s]));
            end
        end
        $display("test field layout done");
        pstrb <= 4'h1;
        apb(1'b1, IPR_OFF_PRIORITY_CTRL_1, 32'h0000_FFFF);
        pstrb <= 4'hF;
        apb(1'b0, IPR_OFF_PRIORITY_CTRL_1, 32'h0);
        chk(rd, 32'h0000_7577);
        $display("test byte strobe done");
        src_req <= 20'h0_8001;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, IPR_OFF_PRIORITY_CTRL_0, 32'(c));
            @(negedge clk_sys);
            chk(32'(src_level[2:0]), 32'(c));
            chk(32'(src_req_gated), 32'(c != 0));
            @(negedge clk_sys);
            chk({28'h0, cpu_req, cpu_level}, 32'((c != 0) * 8 + c));
            chk(32'(win_level), 32'(c));
        end
        $display("test level codes done");
        apb(1'b1, IPR_OFF_PRIORITY_CTRL_1, 32'h0000_0002);
        apb(1'b1, IPR_OFF_PRIORITY_CTRL_0, 32'h0000_7000);
        src_req <= 20'h0_0018;
        repeat (2) @(negedge clk_sys);
        chk(32'(cpu_level), 32'h7);
        apb(1'b1, IPR_OFF_PRIORITY_CTRL_0, 32'h0000_1000);
        repeat (2) @(negedge clk_sys);
        chk(32'(cpu_level), 32'h2);
        chk(32'(win_level), 32'h2);
        $display("test arbitration done");
        apb(1'b1, 12'h014, 32'h0000_FFFF);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h002, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, IPR_OFF_PRIORITY_CTRL_4, 32'h0);
        chk(rd, 32'h0000_7531);
        $display("test unmapped access done");
        conclude();
    end
endmodule
`default_nettype wire
